// [src/uart_sir_core.sv]
// What this block does
// - x16 tick: one-clock pulses at sixteen times baud
// - Transmit queue: sixteen 8-bit entries
// - Receive queue: sixteen 11-bit entries with flags
// - Buffering off gives single-entry queues; receive holds three entries with its skid
// - Start, data LSB first, parity, stop bits
// - Valid start only; check parity, framing, break
// - Four maskable high requests plus their OR
// - Data service requests separate from status requests
// - Inputs crossing in always pass synchronisers
// - Host accesses decoded into queue writes and reads
// - Normal IR pulse lasts three x16 ticks
// - Low-power IR pulse lasts three low-power ticks
// - Low-power tick divides reference clock by divisor plus one
// - IR output rests low, pulses high for zeros
// - Decoder idle high, low flags candidate start
// - Start kept only if low one low-power divisor period later
// - Test mode drives its own tick enable
// - Sixteen-bit down counter reloads divisor at zero
// - Entry: break 10, parity 9, framing 8
// - IR on: wired line high, wired inputs ignored
module uart_sir_core
	import uart_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// Configuration
	input  wire line_cfg_s                    line_cfg,
	input  wire logic [DIVISOR_WIDTH-1:0]     baud_divisor,
	input  wire logic [LP_DIVISOR_WIDTH-1:0]  ir_lowpower_divisor_reg,
	input  wire irq_ctl_s                     irq_ctl,
	// Test
	input  wire logic                         test_mode,
	input  wire logic                         test_step,
	// Host transmit port
	input  wire logic                         tx_wr_valid,
	output logic                              tx_wr_ready,
	input  wire logic [TX_WIDTH-1:0]          tx_wr_data,
	// Host receive port
	output logic                              rx_rd_valid,
	input  wire logic                         rx_rd_ready,
	output rx_entry_s                         rx_rd_data,
	// Serial pins
	output logic                              wired_tx_line,
	input  wire logic                         wired_rx_line,
	output logic                              ir_tx_out_n,
	input  wire logic                         ir_rx_in,
	input  wire logic                         modem_cts,
	input  wire logic                         modem_dcd,
	input  wire logic                         modem_dsr,
	// Status
	output logic                              tx_busy,
	output logic                              rx_overrun,
	output logic [2:0]                        modem_status,
	// Interrupts
	output logic                              rx_service_irq,
	output logic                              tx_service_irq,
	output logic                              rx_timeout_irq,
	output logic                              modem_irq,
	output logic                              combined_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic                 rst_meta_ff;
	logic                 rst_sync_ff;
	logic [PIN_COUNT-1:0] pin_meta_ff;
	logic [PIN_COUNT-1:0] pin_sync_ff;

	wire  [PIN_COUNT-1:0] pin_in = {modem_dsr, modem_dcd, modem_cts, ir_rx_in, wired_rx_line};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pin_meta_ff <= PIN_IDLE;
			pin_sync_ff <= PIN_IDLE;
		end else begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Baud and low-power tick generators
	logic [DIVISOR_WIDTH-1:0]    baud_cnt_ff;
	logic [LP_DIVISOR_WIDTH-1:0] lp_cnt_ff;
	logic                        baud_tick_ff;
	logic                        lp_tick_ff;

	wire baud_zero = baud_cnt_ff == '0;
	wire lp_zero   = lp_cnt_ff == '0;
	wire [DIVISOR_WIDTH-1:0]    nxt_baud_cnt = baud_zero ? baud_divisor :
	                                           baud_cnt_ff - DIVISOR_WIDTH'(1);
	wire [LP_DIVISOR_WIDTH-1:0] nxt_lp_cnt   = lp_zero ? ir_lowpower_divisor_reg :
	                                           lp_cnt_ff - LP_DIVISOR_WIDTH'(1);
	// Test mode replaces both ticks so vectors step the block one tick at a time
	wire x16_baud_tick    = test_mode ? test_step : baud_tick_ff;
	wire lowpower_ir_tick = test_mode ? test_step : lp_tick_ff;

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			baud_cnt_ff  <= '0;
			lp_cnt_ff    <= '0;
			baud_tick_ff <= 1'b0;
			lp_tick_ff   <= 1'b0;
		end else begin
			baud_cnt_ff  <= nxt_baud_cnt;
			lp_cnt_ff    <= nxt_lp_cnt;
			baud_tick_ff <= baud_zero;
			lp_tick_ff   <= lp_zero;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Queues
	localparam int LW = $clog2(DEPTH+1);

	logic                tx_pop;
	logic                txq_valid;
	logic [TX_WIDTH-1:0] txq_data;
	logic [LW-1:0]       tx_level;
	logic                rx_push_ff;
	rx_entry_s           rx_entry_ff;
	logic                rxq_in_ready;
	logic                rxq_valid;
	logic                rxq_ready;
	rx_entry_s           rxq_data;
	logic [LW-1:0]       rx_level;

	sync_fifo #(.WIDTH(TX_WIDTH), .DEPTH(DEPTH)) tx_queue (
		.clock     (clock),
		.rst_n     (rst_sync_ff),
		.one_entry (!line_cfg.fifo_en),
		.in_valid  (tx_wr_valid),
		.in_ready  (tx_wr_ready),
		.in_data   (tx_wr_data),
		.out_valid (txq_valid),
		.out_ready (tx_pop),
		.out_data  (txq_data),
		.level     (tx_level)
	);

	sync_fifo #(.WIDTH(RX_WIDTH), .DEPTH(DEPTH)) rx_queue (
		.clock     (clock),
		.rst_n     (rst_sync_ff),
		.one_entry (!line_cfg.fifo_en),
		.in_valid  (rx_push_ff),
		.in_ready  (rxq_in_ready),
		.in_data   (rx_entry_ff),
		.out_valid (rxq_valid),
		.out_ready (rxq_ready),
		.out_data  (rxq_data),
		.level     (rx_level)
	);

	// Skid stage lets the host stall without losing the word at the queue head
	sync_fifo #(.WIDTH(RX_WIDTH), .DEPTH(SKID_DEPTH)) rx_skid (
		.clock     (clock),
		.rst_n     (rst_sync_ff),
		.one_entry (1'b0),
		.in_valid  (rxq_valid),
		.in_ready  (rxq_ready),
		.in_data   (rxq_data),
		.out_valid (rx_rd_valid),
		.out_ready (rx_rd_ready),
		.out_data  (rx_rd_data),
		.level     ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter
	tx_state_e           tx_state_ff;
	tx_state_e           nxt_tx_state;
	logic [3:0]          tx_tick_ff;
	logic [2:0]          tx_idx_ff;
	logic [TX_WIDTH-1:0] tx_shift_ff;
	logic                tx_stop2_ff;

	wire [2:0] last_idx  = FIVE_BITS_LAST + {1'b0, line_cfg.word_len};
	wire       tx_end    = x16_baud_tick && (tx_tick_ff == TICK_LAST);
	// Bits above the word length must not enter the parity sum
	wire [7:0] tx_mask   = 8'hFF >> (3'h7 - last_idx);
	wire       tx_parity = (^(tx_shift_ff & tx_mask)) ^ !line_cfg.even_parity;
	wire       tx_last   = tx_idx_ff == last_idx;
	wire       stop_done = !line_cfg.two_stop || tx_stop2_ff;

	assign tx_pop = (tx_state_ff == TX_IDLE) && txq_valid;

	always_comb begin
		nxt_tx_state = tx_state_ff;
		case (tx_state_ff)
			TX_IDLE:   if (txq_valid) nxt_tx_state = TX_START;
			TX_START:  if (tx_end) nxt_tx_state = TX_DATA;
			TX_DATA:   if (tx_end && tx_last) begin
				nxt_tx_state = line_cfg.parity_en ? TX_PARITY : TX_STOP;
			end
			TX_PARITY: if (tx_end) nxt_tx_state = TX_STOP;
			TX_STOP:   if (tx_end && stop_done) nxt_tx_state = TX_IDLE;
			default:   nxt_tx_state = TX_IDLE;
		endcase
	end

	// NRZ bit for the current state; break forces spacing
	logic serial_bit;
	always_comb begin
		case (tx_state_ff)
			TX_START:  serial_bit = 1'b0;
			TX_DATA:   serial_bit = tx_shift_ff[tx_idx_ff];
			TX_PARITY: serial_bit = tx_parity;
			default:   serial_bit = 1'b1;
		endcase
	end
	wire tx_bit = serial_bit && !line_cfg.send_break;

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			tx_state_ff <= TX_IDLE;
			tx_tick_ff  <= '0;
			tx_idx_ff   <= '0;
			tx_shift_ff <= '0;
			tx_stop2_ff <= 1'b0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_tick_ff  <= tx_pop ? '0 : tx_tick_ff + 4'(x16_baud_tick);
			tx_shift_ff <= tx_pop ? txq_data : tx_shift_ff;
			tx_idx_ff   <= (tx_state_ff == TX_DATA && tx_end) ? tx_idx_ff + 3'h1 :
			               (tx_state_ff == TX_DATA) ? tx_idx_ff : '0;
			tx_stop2_ff <= (tx_state_ff == TX_STOP) ? (tx_stop2_ff ^ tx_end) : 1'b0;
		end
	end

	assign tx_busy = txq_valid || (tx_state_ff != TX_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// IR encoder and wired output
	logic       ir_pulse_ff;
	logic [1:0] ir_pulse_cnt_ff;
	logic       wired_tx_ff;

	wire pulse_tick = line_cfg.ir_lowpower ? lowpower_ir_tick : x16_baud_tick;
	wire bit_first  = x16_baud_tick && (tx_tick_ff == 4'h0) && (tx_state_ff != TX_IDLE);
	wire ir_start   = line_cfg.ir_enable && bit_first && !tx_bit;
	wire ir_stop    = pulse_tick && (ir_pulse_cnt_ff == PULSE_LAST);

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ir_pulse_ff     <= 1'b0;
			ir_pulse_cnt_ff <= '0;
			wired_tx_ff     <= 1'b1;
		end else begin
			ir_pulse_ff     <= ir_start || (ir_pulse_ff && !ir_stop);
			ir_pulse_cnt_ff <= ir_start ? '0 : ir_pulse_cnt_ff + 2'(pulse_tick);
			wired_tx_ff     <= line_cfg.ir_enable || tx_bit;
		end
	end

	assign ir_tx_out_n   = ir_pulse_ff;
	assign wired_tx_line = wired_tx_ff;

	////////////////////////////////////////////////////////////////////////////////
	// IR decoder
	logic                      ir_wait_ff;
	logic [LP_DIVISOR_WIDTH:0] ir_wait_cnt_ff;
	logic                      ir_stretch_ff;
	logic [3:0]                ir_stretch_cnt_ff;

	wire ir_in        = pin_sync_ff[PIN_IR_RX];
	// Candidates stay live while stretching so back-to-back zeros retrigger
	wire ir_candidate = !ir_wait_ff && !ir_in;
	wire ir_wait_done = ir_wait_ff &&
	                    (ir_wait_cnt_ff == {1'b0, ir_lowpower_divisor_reg});
	wire ir_accept    = ir_wait_done && !ir_in;
	wire ir_str_end   = x16_baud_tick && (ir_stretch_cnt_ff == TICK_LAST);

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ir_wait_ff        <= 1'b0;
			ir_wait_cnt_ff    <= '0;
			ir_stretch_ff     <= 1'b0;
			ir_stretch_cnt_ff <= '0;
		end else begin
			ir_wait_ff        <= ir_candidate || (ir_wait_ff && !ir_wait_done);
			ir_wait_cnt_ff    <= ir_wait_ff ? ir_wait_cnt_ff + (LP_DIVISOR_WIDTH+1)'(1) : '0;
			ir_stretch_ff     <= ir_accept || (ir_stretch_ff && !ir_str_end);
			ir_stretch_cnt_ff <= ir_accept ? '0 : ir_stretch_cnt_ff + 4'(x16_baud_tick);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	rx_state_e  rx_state_ff;
	rx_state_e  nxt_rx_state;
	logic [3:0] rx_tick_ff;
	logic [2:0] rx_idx_ff;
	logic [7:0] rx_data_ff;
	logic       rx_pbit_ff;
	logic       overrun_ff;

	wire rx_line   = line_cfg.ir_enable ? !ir_stretch_ff : pin_sync_ff[PIN_WIRED_RX];
	wire rx_detect = (rx_state_ff == RX_IDLE) && !rx_line;
	wire sample    = x16_baud_tick && (rx_tick_ff == SAMPLE_POINT);
	wire rx_last   = rx_idx_ff == last_idx;
	wire par_err   = line_cfg.parity_en &&
	                 ((^rx_data_ff) ^ rx_pbit_ff ^ !line_cfg.even_parity);
	wire brk_err   = (rx_data_ff == 8'h00) && !rx_pbit_ff && !rx_line;
	wire rx_done   = (rx_state_ff == RX_STOP) && sample;

	always_comb begin
		nxt_rx_state = rx_state_ff;
		case (rx_state_ff)
			RX_IDLE:   if (!rx_line) nxt_rx_state = RX_START;
			RX_START:  if (sample) nxt_rx_state = rx_line ? RX_IDLE : RX_DATA;
			RX_DATA:   if (sample && rx_last) begin
				nxt_rx_state = line_cfg.parity_en ? RX_PARITY : RX_STOP;
			end
			RX_PARITY: if (sample) nxt_rx_state = RX_STOP;
			RX_STOP:   if (sample) nxt_rx_state = RX_IDLE;
			default:   nxt_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rx_state_ff <= RX_IDLE;
			rx_tick_ff  <= '0;
			rx_idx_ff   <= '0;
			rx_data_ff  <= '0;
			rx_pbit_ff  <= 1'b0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rx_tick_ff  <= rx_detect ? '0 : rx_tick_ff + 4'(x16_baud_tick);
			rx_idx_ff   <= (rx_state_ff == RX_DATA) ? rx_idx_ff + 3'(sample) : '0;
			rx_data_ff  <= rx_detect ? '0 : rx_data_ff;
			rx_pbit_ff  <= rx_detect ? 1'b0 :
			               (rx_state_ff == RX_PARITY && sample) ? rx_line : rx_pbit_ff;
			if (rx_state_ff == RX_DATA && sample) begin
				rx_data_ff[rx_idx_ff] <= rx_line;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rx_push_ff  <= 1'b0;
			rx_entry_ff <= '0;
			overrun_ff  <= 1'b0;
		end else begin
			rx_push_ff  <= rx_done;
			rx_entry_ff <= rx_done ? {brk_err, par_err, !rx_line, rx_data_ff} : rx_entry_ff;
			// A dropped character wins over a clear in the same cycle
			overrun_ff  <= (rx_push_ff && !rxq_in_ready) || (overrun_ff && !irq_ctl.overrun_clr);
		end
	end

	assign rx_overrun = overrun_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Receive timeout and modem change
	logic [9:0] timeout_cnt_ff;
	logic       timeout_ff;
	logic [2:0] modem_prev_ff;
	logic       modem_flag_ff;

	wire        timeout_arm  = rxq_valid && (rx_state_ff == RX_IDLE) && !rxq_ready;
	wire [2:0]  modem_now    = pin_sync_ff[PIN_MODEM_LO +: 3];
	wire        modem_change = !line_cfg.ir_enable && (modem_now != modem_prev_ff);

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			timeout_cnt_ff <= '0;
			timeout_ff     <= 1'b0;
			modem_prev_ff  <= '0;
			modem_flag_ff  <= 1'b0;
		end else begin
			timeout_cnt_ff <= !timeout_arm ? '0 :
			                  (timeout_cnt_ff == TIMEOUT_TICKS) ? timeout_cnt_ff :
			                  timeout_cnt_ff + 10'(x16_baud_tick);
			timeout_ff     <= timeout_arm && (timeout_cnt_ff == TIMEOUT_TICKS);
			modem_prev_ff  <= line_cfg.ir_enable ? modem_prev_ff : modem_now;
			modem_flag_ff  <= modem_change || (modem_flag_ff && !irq_ctl.modem_clr);
		end
	end

	assign modem_status = modem_prev_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt outputs
	logic [3:0] irq_ff;

	wire [4:0] rx_lvl = 5'(rx_level);
	wire [4:0] tx_lvl = 5'(tx_level);
	wire rx_req = line_cfg.fifo_en ? (rx_lvl >= RX_TRIGGER) : (rx_lvl != 5'h00);
	wire tx_req = line_cfg.fifo_en ? (tx_lvl <= TX_TRIGGER) : (tx_lvl == 5'h00);
	wire [3:0] irq_raw = {modem_flag_ff, timeout_ff, tx_req, rx_req};

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			irq_ff <= '0;
		end else begin
			irq_ff <= irq_raw & irq_ctl.mask;
		end
	end

	assign rx_service_irq = irq_ff[0];
	assign tx_service_irq = irq_ff[1];
	assign rx_timeout_irq = irq_ff[2];
	assign modem_irq      = irq_ff[3];
	assign combined_irq   = |irq_ff;

endmodule : uart_sir_core

// [src/uart_pkg.sv]
package uart_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and depths
	localparam int TX_WIDTH          = 8;
	localparam int RX_WIDTH          = 11;
	localparam int FIFO_DEPTH        = 16;
	localparam int SKID_DEPTH        = 2;
	localparam int DIVISOR_WIDTH     = 16;
	localparam int LP_DIVISOR_WIDTH  = 8;
	localparam int PIN_COUNT         = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Receive entry field positions
	localparam int BREAK_BIT         = 10;
	localparam int PARITY_BIT        = 9;
	localparam int FRAMING_BIT       = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Pin vector positions and reset levels
	localparam int PIN_WIRED_RX      = 0;
	localparam int PIN_IR_RX         = 1;
	localparam int PIN_MODEM_LO      = 2;
	localparam logic [4:0] PIN_IDLE  = 5'h03;

	////////////////////////////////////////////////////////////////////////////////
	// Timing, in x16 ticks unless named otherwise; queue triggers in entries, FIVE_BITS_LAST a bit index
	localparam int CLOCK_PERIOD_NS   = 100;
	localparam logic [3:0] TICK_LAST    = 4'hF;
	localparam logic [3:0] SAMPLE_POINT = 4'h7;
	localparam logic [1:0] PULSE_LAST   = 2'h2;
	localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
	localparam logic [4:0] RX_TRIGGER   = 5'h08;
	localparam logic [4:0] TX_TRIGGER   = 5'h08;
	localparam logic [2:0] FIVE_BITS_LAST = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic       brk;
		logic       par;
		logic       frm;
		logic [7:0] data;
	} rx_entry_s;

	typedef struct packed {
		logic [1:0] word_len;
		logic       parity_en;
		logic       even_parity;
		logic       two_stop;
		logic       send_break;
		logic       fifo_en;
		logic       ir_enable;
		logic       ir_lowpower;
	} line_cfg_s;

	typedef struct packed {
		logic [3:0] mask;
		logic       modem_clr;
		logic       overrun_clr;
	} irq_ctl_s;

	typedef enum logic [4:0] {
		TX_IDLE   = 5'h01,
		TX_START  = 5'h02,
		TX_DATA   = 5'h04,
		TX_PARITY = 5'h08,
		TX_STOP   = 5'h10
	} tx_state_e;

	typedef enum logic [4:0] {
		RX_IDLE   = 5'h01,
		RX_START  = 5'h02,
		RX_DATA   = 5'h04,
		RX_PARITY = 5'h08,
		RX_STOP   = 5'h10
	} rx_state_e;

endpackage : uart_pkg

// [src/sync_fifo.sv]
module sync_fifo
	import uart_pkg::*;
#(
	parameter int WIDTH = TX_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// Mode
	input  wire logic                         one_entry,
	// Fill side
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [WIDTH-1:0]             in_data,
	// Drain side
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [WIDTH-1:0]                  out_data,
	output logic [$clog2(DEPTH+1)-1:0]        level
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [CW-1:0]    count_ff;
	logic [CW-1:0]    nxt_count;

	wire  [CW-1:0]    limit    = one_entry ? CW'(1) : CW'(DEPTH);
	wire              push     = in_valid & in_ready;
	wire              pop      = out_valid & out_ready;
	wire  [PW-1:0]    nxt_wr   = (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + PW'(1);
	wire  [PW-1:0]    nxt_rd   = (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + PW'(1);

	// Full is judged against the active limit so one-entry mode back-pressures early
	assign in_ready  = count_ff < limit;
	assign out_valid = count_ff != '0;
	assign out_data  = mem_ff[rd_ptr_ff];
	assign level     = count_ff;
	assign nxt_count = (push && !pop) ? count_ff + CW'(1) :
	                   (pop && !push) ? count_ff - CW'(1) : count_ff;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			wr_ptr_ff <= push ? nxt_wr : wr_ptr_ff;
			rd_ptr_ff <= pop ? nxt_rd : rd_ptr_ff;
			count_ff  <= nxt_count;
		end
	end

endmodule : sync_fifo

// [test/uart_sir_core_chk.sv]
module uart_sir_core_chk
	import uart_pkg::*;
(
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	// Controls
	input  wire line_cfg_s                line_cfg,
	input  wire logic [DIVISOR_WIDTH-1:0] baud_divisor,
	input  wire irq_ctl_s                 irq_ctl,
	// Host side
	input  wire logic                     tx_wr_valid,
	input  wire logic                     tx_wr_ready,
	input  wire logic                     rx_rd_valid,
	input  wire logic                     rx_rd_ready,
	input  wire rx_entry_s                rx_rd_data,
	// Pins and status
	input  wire logic                     wired_tx_line,
	input  wire logic                     ir_tx_out_n,
	input  wire logic                     tx_busy,
	input  wire logic                     rx_overrun,
	// Interrupts
	input  wire logic                     rx_service_irq,
	input  wire logic                     tx_service_irq,
	input  wire logic                     rx_timeout_irq,
	input  wire logic                     modem_irq,
	input  wire logic                     combined_irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	logic [19:0] high_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) high_ff <= 20'h0;
		else high_ff <= ir_tx_out_n ? high_ff + 20'h1 : 20'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_IRQ_OR: assert property (
		combined_irq == (rx_service_irq || tx_service_irq || rx_timeout_irq || modem_irq))
		else $error("combined irq wrong");
	AST_RX_MASK: assert property (!irq_ctl.mask[0] |=> !rx_service_irq)
		else $error("masked rx irq seen");
	AST_TX_MASK: assert property (!irq_ctl.mask[1] |=> !tx_service_irq)
		else $error("masked tx irq seen");
	AST_IR_PULSE: assert property (
		$fell(ir_tx_out_n) && !line_cfg.ir_lowpower |-> high_ff == 3 * (baud_divisor + 1))
		else $error("ir pulse width wrong");
	AST_START_BIT: assert property (tx_wr_valid && tx_wr_ready && !tx_busy &&
		!line_cfg.ir_enable && !line_cfg.send_break |-> ##[1:3] !wired_tx_line)
		else $error("no start bit");
	AST_BUSY_SET: assert property (tx_wr_valid && tx_wr_ready |=> tx_busy)
		else $error("busy not set");
	AST_RX_HOLD: assert property (
		rx_rd_valid && !rx_rd_ready |=> rx_rd_valid && $stable(rx_rd_data))
		else $error("rx entry dropped");
	AST_IDLE_HIGH: assert property (
		!tx_busy && !$past(tx_busy) && !line_cfg.send_break |-> wired_tx_line)
		else $error("idle line low");
	AST_IR_REST: assert property (!tx_busy && !$past(tx_busy) |-> !ir_tx_out_n)
		else $error("ir out not resting");
	AST_IR_WIRED: assert property (
		line_cfg.ir_enable && $past(line_cfg.ir_enable) |-> wired_tx_line)
		else $error("wired line moved in ir mode");
	AST_OVR_STICKY: assert property (rx_overrun && !irq_ctl.overrun_clr |=> rx_overrun)
		else $error("overrun lost");
endmodule : uart_sir_core_chk

bind uart_sir_core uart_sir_core_chk uart_sir_core_chk_i (
	.clock, .rst_n, .line_cfg, .baud_divisor, .irq_ctl, .tx_wr_valid, .tx_wr_ready,
	.rx_rd_valid, .rx_rd_ready, .rx_rd_data, .wired_tx_line, .ir_tx_out_n, .tx_busy,
	.rx_overrun, .rx_service_irq, .tx_service_irq, .rx_timeout_irq, .modem_irq, .combined_irq
);

// [test/serial_peer.sv]
module serial_peer #(
	parameter int BIT = 32
) (
	input  wire logic clock,
	input  wire logic ir,
	input  wire logic tx_line,
	output logic      rx_line,
	output logic      ir_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic       nrz = 1'b1;
	logic       tog = 1'b0;
	// Wired line carries junk while the optical path is in use
	assign rx_line = ir ? tog : nrz;
	always @(posedge clock) tog <= ~tog;
	initial ir_line = 1'b1;
	task automatic send(input logic [7:0] b, input logic stop);
		logic [10:0] f;
		f = {1'b1, stop, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			for (int j = 0; j < BIT; j++) begin
				nrz <= f[i];
				ir_line <= !(ir && !f[i] && j < 3 * BIT / 16);
				@(posedge clock);
			end
		end
	endtask : send
	task automatic glitch();
		ir_line <= 1'b0;
		@(posedge clock);
		ir_line <= 1'b1;
		repeat (BIT) @(posedge clock);
	endtask : glitch
	initial forever begin
		logic [7:0] d;
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock);
			d[i] = tx_line;
		end
		got.push_back(d);
	end
endmodule : serial_peer

// [test/uart_sir_core_test.sv]
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module uart_sir_core_test
	import uart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst_n, tx_wr_valid, tx_wr_ready, rx_rd_valid, rx_rd_ready;
	logic        wired_tx_line, wired_rx_line, ir_tx_out_n, ir_rx_in, tx_busy, rx_overrun;
	logic        rx_service_irq, tx_service_irq, rx_timeout_irq, modem_irq, combined_irq;
	logic [2:0]  modem, modem_status;
	logic [7:0]  tx_wr_data, sent[$];
	line_cfg_s   line_cfg;
	irq_ctl_s    irq_ctl;
	rx_entry_s   rx_rd_data, exp_rx[$];
	int          errors, checks_done, cycles;
	logic [31:0] seed = 32'h783DD99E;
	uart_sir_core uart_sir_core_i (.clock, .rst_n, .line_cfg, .baud_divisor(16'h0001),
		.ir_lowpower_divisor_reg(8'h03), .irq_ctl, .test_mode(1'b0), .test_step(1'b0),
		.tx_wr_valid, .tx_wr_ready, .tx_wr_data, .rx_rd_valid, .rx_rd_ready, .rx_rd_data,
		.wired_tx_line, .wired_rx_line, .ir_tx_out_n, .ir_rx_in, .modem_cts(modem[0]),
		.modem_dcd(modem[1]), .modem_dsr(modem[2]), .tx_busy, .rx_overrun, .modem_status,
		.rx_service_irq, .tx_service_irq, .rx_timeout_irq, .modem_irq, .combined_irq);
	serial_peer #(.BIT(32)) serial_peer_i (.clock, .ir(line_cfg.ir_enable),
		.tx_line(wired_tx_line), .rx_line(wired_rx_line), .ir_line(ir_rx_in));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic report_and_stop();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input int n);
		for (int i = 0; i < n; i++) begin
			tx_wr_data <= 8'(rnd());
			tx_wr_valid <= 1'b1;
			do @(posedge clock); while (tx_wr_ready !== 1'b1);
			sent.push_back(tx_wr_data);
		end
		tx_wr_valid <= 1'b0;
	endtask : wr
	task automatic wait_idle();
		do @(posedge clock); while (tx_busy !== 1'b0);
	endtask : wait_idle
	task automatic rx(input logic [7:0] b, input logic stop);
		exp_rx.push_back({b == 8'h00 && !stop, 1'b0, !stop, b});
		serial_peer_i.send(b, stop);
	endtask : rx
	task automatic rd();
		rx_entry_s e;
		rx_rd_ready <= 1'b1;
		repeat (40) begin
			@(posedge clock);
			if (rx_rd_valid === 1'b1) begin
				e = (exp_rx.size() > 0) ? exp_rx.pop_front() : 'x;
				`CHK(rx_rd_data, e)
			end
		end
		rx_rd_ready <= 1'b0;
	endtask : rd
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		rst_n = 1'b0;
		{tx_wr_valid, rx_rd_ready, tx_wr_data, modem} = '0;
		line_cfg = 9'h184;
		irq_ctl = 6'h08;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		modem <= 3'(rnd());
		line_cfg.fifo_en <= 1'b0;
		wr(3);
		@(posedge clock);
		`CHK(tx_wr_ready, 1'b0)
		wait_idle();
		line_cfg.fifo_en <= 1'b1;
		wr(20);
		wait_idle();
		`CHK(tx_service_irq, 1'b1)
		`CHK(modem_status, modem)
		foreach (sent[i]) `CHK(serial_peer_i.got[i], sent[i])
		irq_ctl <= 6'h3C;
		rx(8'(rnd()), 1'b1);
		rx(8'hA5, 1'b0);
		rx(8'h00, 1'b0);
		repeat (1100) @(posedge clock);
		`CHK(rx_timeout_irq, 1'b1)
		rd();
		`CHK(exp_rx.size(), 0)
		repeat (20) rx(8'(rnd()), 1'b1);
		`CHK(rx_service_irq, 1'b1)
		`CHK(combined_irq, 1'b1)
		`CHK(rx_overrun, 1'b1)
		rd();
		`CHK(1'(exp_rx.size() <= 4), 1'b1)
		exp_rx.delete();
		irq_ctl.overrun_clr <= 1'b1;
		@(posedge clock);
		irq_ctl.overrun_clr <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(rx_overrun, 1'b0)
		line_cfg.ir_enable <= 1'b1;
		repeat (4) @(posedge clock);
		serial_peer_i.glitch();
		rx(8'(rnd()), 1'b1);
		rd();
		`CHK(exp_rx.size(), 0)
		wr(2);
		wait_idle();
		line_cfg.ir_lowpower <= 1'b1;
		wr(1);
		wait_idle();
		`CHK(serial_peer_i.got.size(), sent.size() - 3)
		report_and_stop();
	end
endmodule : uart_sir_core_test
